// [core/dws_consts.svh]
// register map, field positions and reset values of the waveform sequencer
//
// Behaviour
// [RQ1] post-trigger: output starts at once on trigger, trigger delay unused
// [RQ2] delay-trigger: delay counter counts down per clock tick, output starts at zero
// [RQ3] trigger delay is 16 bits, clocked by timebase or update period
// [RQ4] re-trigger enabled by software; count limits further accepted triggers
// [RQ5] each accepted trigger produces iteration_count complete waveforms
// [RQ6] triggers arriving during a generation sequence are discarded
// [RQ7] finite iteration count or infinite mode until software stop
// [RQ8] waveform fits buffer: load once, replay buffer after each waveform
// [RQ9] waveform exceeds buffer: keep refilling from host throughout generation
// [RQ10] buffer holds 1024 words single channel, 512 per channel dual
// [RQ11] gap counter counts down after each waveform; next starts at zero
// [RQ12] gap counter is 16 bits, clocked by timebase or update period
// [RQ13] software stop honoured in finite and infinite modes, three stop modes
// [RQ14] stop mode one halts output immediately
// [RQ15] stop mode two finishes the current waveform first
// [RQ16] stop mode three runs until waveform total is multiple of iterations
// [RQ17] iteration count is stop granularity in infinite mode with stop mode three
// [RQ18] trigger source selectable: software, analog or digital
// [RQ19] one update strobe pulse per sample, output valid at its rising edge
// [RQ20] update interval counter is 24 bits, spacing is count timebase cycles
// [RQ21] samples per waveform counter is 24 bits
// [RQ22] after stop or finite end, go idle, no strobes, wait for new start
// [RQ23] separate clock selection for trigger delay and gap counters
`ifndef DWS_CONSTS_SVH
`define DWS_CONSTS_SVH

`define DWS_ADDR_W          8
`define DWS_OFS_CTRL        8'h00
`define DWS_OFS_CONFIG      8'h04
`define DWS_OFS_INTERVAL    8'h08
`define DWS_OFS_SAMPLES     8'h0c
`define DWS_OFS_ITER        8'h10
`define DWS_OFS_TRIG_DELAY  8'h14
`define DWS_OFS_GAP         8'h18
`define DWS_OFS_RETRIG      8'h1c
`define DWS_OFS_STATUS      8'h20

// control bits, write one to act
`define DWS_CTRL_START      0
`define DWS_CTRL_STOP       1
`define DWS_CTRL_SWTRIG     2
`define DWS_CTRL_CLR_UNDER  3
`define DWS_CTRL_FLUSH      4

// config field positions
`define DWS_CFG_SRC_LO      0
`define DWS_CFG_SRC_HI      1
`define DWS_CFG_DELAY_MODE  2
`define DWS_CFG_RETRIG_EN   3
`define DWS_CFG_INFINITE    4
`define DWS_CFG_STOP_LO     5
`define DWS_CFG_STOP_HI     6
`define DWS_CFG_DLY_UPD     7
`define DWS_CFG_GAP_UPD     8
`define DWS_CFG_DUAL        9
`define DWS_CFG_W           10

`define DWS_CFG_RESET       10'h000
`define DWS_INTERVAL_RESET  24'h000028
`define DWS_SAMPLES_RESET   24'h000001
`define DWS_ITER_RESET      24'h000001

`define DWS_SRC_SW          2'h0
`define DWS_SRC_ANALOG      2'h1
`define DWS_SRC_DIGITAL     2'h2
`define DWS_STOP_NOW        2'h0
`define DWS_STOP_WAVE       2'h1
`define DWS_STOP_GROUP      2'h2

`endif

// [core/dws_pkg.sv]
// types shared by the waveform sequencer
package dws_pkg;
   typedef enum logic [2:0] {
      DWS_IDLE,
      DWS_ARMED,
      DWS_DELAY,
      DWS_RUN,
      DWS_GAP
   } dws_seq_type;
endpackage

// [core/dws_sequencer.sv]
// timed waveform sequencer for a two-channel converter output path
`timescale 1ns/100ps
`include "dws_consts.svh"
module dws_sequencer #(
   parameter int DEPTH = 1024,
   parameter int DW    = 12
) (
   // clock and reset
   input  wire logic                   CLOCK,
   input  wire logic                   RST,
   // register port
   input  wire logic [`DWS_ADDR_W-1:0] ADDR,
   input  wire logic [31:0]            WDATA,
   input  wire logic                   WR,
   input  wire logic                   RD,
   output logic      [31:0]            RDATA,
   // sample stream from host dma
   input  wire logic [DW-1:0]          SAMPLE_DATA,
   input  wire logic                   SAMPLE_VALID,
   output logic                        SAMPLE_READY,
   // trigger pins
   input  wire logic                   ANALOG_TRIG,
   input  wire logic                   DIGITAL_TRIG,
   // converter side
   output logic      [DW-1:0]          CH0_DATA,
   output logic      [DW-1:0]          CH1_DATA,
   output logic                        CONVERTER_UPDATE_STROBE,
   output logic                        BUSY
);
   import dws_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      dws_seq_type           seq;
      logic [23:0]           ui_cnt;
      logic [15:0]           dly_cnt;
      logic [23:0]           smp_cnt;
      logic [23:0]           iter_cnt;
      logic [15:0]           retrig_left;
      logic                  stop_pend;
      logic [AW-1:0]         rd_ptr;
      logic [AW-1:0]         wr_ptr;
      logic [AW:0]           fill;
      logic                  underrun;
      logic [`DWS_CFG_W-1:0] cfg;
      logic [23:0]           interval;
      logic [23:0]           samples;
      logic [23:0]           iter;
      logic [15:0]           trig_delay;
      logic [15:0]           gap;
      logic [15:0]           retrig;
      logic [2:0]            atrig_sync;
      logic [2:0]            dtrig_sync;
      logic [DW-1:0]         ch0;
      logic [DW-1:0]         ch1;
      logic                  strobe;
      logic [31:0]           rdata;
   } dws_regs_type;

   dws_regs_type st_ff;
   dws_regs_type nxt_st;

   logic [DW-1:0] mem [DEPTH];

   // pointer arithmetic wraps at the buffer depth
   function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p, input logic [1:0] k);
      logic [AW:0] s;
      s = {1'b0, p} + {{(AW-1){1'b0}}, k};
      if (s >= (AW+1)'(DEPTH)) begin
         s = s - (AW+1)'(DEPTH);
      end
      return s[AW-1:0];
   endfunction

   logic          dual;
   logic [1:0]    wpu;
   logic [AW:0]   cap_upd;
   logic          replay;
   logic [AW:0]   load_limit;
   logic          wr_take;
   logic          start_cmd;
   logic          stop_cmd;
   logic          trig_evt;
   logic          upd_tick;
   logic          dly_tick;
   logic          gap_tick;
   logic          rd_take;
   logic          wave_end;
   logic          group_end;
   logic          stop_here;
   logic [23:0]   iter_next;
   logic [1:0]    stop_mode;
   logic [AW:0]   fill_tmp;

   assign dual       = st_ff.cfg[`DWS_CFG_DUAL];
   assign wpu        = dual ? 2'h2 : 2'h1;
   assign cap_upd    = dual ? (AW+1)'(DEPTH / 2) : (AW+1)'(DEPTH); // RQ10
   // short waveform stays resident and is replayed
   assign replay     = st_ff.samples <= {{(23-AW){1'b0}}, cap_upd}; // RQ8 RQ9
   assign load_limit = replay ? (AW+1)'(st_ff.samples * wpu) : (AW+1)'(DEPTH);
   assign stop_mode  = st_ff.cfg[`DWS_CFG_STOP_HI:`DWS_CFG_STOP_LO];

   // host refill back-pressure
   assign SAMPLE_READY = st_ff.fill < load_limit; // RQ9
   assign wr_take      = SAMPLE_VALID && SAMPLE_READY;

   always_ff @(posedge CLOCK) begin
      if (wr_take) begin
         mem[st_ff.wr_ptr] <= SAMPLE_DATA;
      end
   end

   assign start_cmd = WR && ADDR == `DWS_OFS_CTRL && WDATA[`DWS_CTRL_START];
   assign stop_cmd  = WR && ADDR == `DWS_OFS_CTRL && WDATA[`DWS_CTRL_STOP];

   // trigger source select, pins edge-detected after synchronising
   always_comb begin
      unique case (st_ff.cfg[`DWS_CFG_SRC_HI:`DWS_CFG_SRC_LO])
         `DWS_SRC_ANALOG: trig_evt = st_ff.atrig_sync[1] && !st_ff.atrig_sync[2]; // RQ18
         `DWS_SRC_DIGITAL: trig_evt = st_ff.dtrig_sync[1] && !st_ff.dtrig_sync[2]; // RQ18
         default: trig_evt = WR && ADDR == `DWS_OFS_CTRL && WDATA[`DWS_CTRL_SWTRIG]; // RQ18
      endcase
   end

   // update period tick, interval of zero acts as one
   assign upd_tick = st_ff.ui_cnt + 24'h000001 >= st_ff.interval; // RQ20
   assign dly_tick = st_ff.cfg[`DWS_CFG_DLY_UPD] ? upd_tick : 1'b1; // RQ3 RQ23
   assign gap_tick = st_ff.cfg[`DWS_CFG_GAP_UPD] ? upd_tick : 1'b1; // RQ12 RQ23

   assign rd_take   = st_ff.seq == DWS_RUN && upd_tick && st_ff.fill >= {{(AW-1){1'b0}}, wpu};
   assign wave_end  = rd_take && st_ff.smp_cnt + 24'h000001 >= st_ff.samples; // RQ21
   assign iter_next = st_ff.iter_cnt + 24'h000001;
   assign group_end = iter_next >= st_ff.iter; // RQ5 RQ17
   // stop at a waveform boundary for the deferred modes
   assign stop_here = (st_ff.stop_pend || stop_cmd)
                      && (stop_mode == `DWS_STOP_WAVE || (stop_mode == `DWS_STOP_GROUP && group_end)); // RQ15 RQ16

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.strobe = 1'b0;
      nxt_st.rdata  = 32'h00000000;
      fill_tmp      = st_ff.fill;

      nxt_st.atrig_sync = {st_ff.atrig_sync[1:0], ANALOG_TRIG};
      nxt_st.dtrig_sync = {st_ff.dtrig_sync[1:0], DIGITAL_TRIG};

      // register writes
      if (WR) begin
         unique case (ADDR)
            `DWS_OFS_CONFIG: nxt_st.cfg = WDATA[`DWS_CFG_W-1:0];
            `DWS_OFS_INTERVAL: nxt_st.interval = WDATA[23:0];
            `DWS_OFS_SAMPLES: nxt_st.samples = WDATA[23:0];
            `DWS_OFS_ITER: nxt_st.iter = WDATA[23:0];
            `DWS_OFS_TRIG_DELAY: nxt_st.trig_delay = WDATA[15:0];
            `DWS_OFS_GAP: nxt_st.gap = WDATA[15:0];
            `DWS_OFS_RETRIG: nxt_st.retrig = WDATA[15:0];
            default: ;
         endcase
      end
      if (WR && ADDR == `DWS_OFS_CTRL && WDATA[`DWS_CTRL_CLR_UNDER]) begin
         nxt_st.underrun = 1'b0;
      end

      // register reads, data in the following cycle
      if (RD) begin
         unique case (ADDR)
            `DWS_OFS_CONFIG: nxt_st.rdata = {{(32-`DWS_CFG_W){1'b0}}, st_ff.cfg};
            `DWS_OFS_INTERVAL: nxt_st.rdata = {8'h00, st_ff.interval};
            `DWS_OFS_SAMPLES: nxt_st.rdata = {8'h00, st_ff.samples};
            `DWS_OFS_ITER: nxt_st.rdata = {8'h00, st_ff.iter};
            `DWS_OFS_TRIG_DELAY: nxt_st.rdata = {16'h0000, st_ff.trig_delay};
            `DWS_OFS_GAP: nxt_st.rdata = {16'h0000, st_ff.gap};
            `DWS_OFS_RETRIG: nxt_st.rdata = {16'h0000, st_ff.retrig};
            `DWS_OFS_STATUS: nxt_st.rdata = {{(24-AW){1'b0}}, st_ff.fill,
                                             st_ff.underrun, replay, st_ff.stop_pend, 1'b0, st_ff.seq};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end

      // buffer fill side
      if (wr_take) begin
         nxt_st.wr_ptr = ptr_add(st_ff.wr_ptr, 2'h1);
         fill_tmp      = fill_tmp + (AW+1)'(1);
      end

      // update counter runs only while a sequence is timed
      if (st_ff.seq == DWS_IDLE || st_ff.seq == DWS_ARMED) begin
         nxt_st.ui_cnt = 24'h000000;
      end else if (upd_tick) begin
         nxt_st.ui_cnt = 24'h000000;
      end else begin
         nxt_st.ui_cnt = st_ff.ui_cnt + 24'h000001;
      end

      unique case (st_ff.seq)
         DWS_IDLE: begin
            if (start_cmd) begin
               nxt_st.seq         = DWS_ARMED;
               nxt_st.retrig_left = st_ff.retrig;
               nxt_st.stop_pend   = 1'b0;
               if (replay) begin
                  nxt_st.rd_ptr = '0;
               end
            end
         end
         DWS_ARMED: begin
            if (stop_cmd) begin
               nxt_st.seq = DWS_IDLE;
            end else if (trig_evt) begin // RQ6
               nxt_st.iter_cnt = 24'h000000;
               nxt_st.smp_cnt  = 24'h000000;
               if (st_ff.cfg[`DWS_CFG_DELAY_MODE] && st_ff.trig_delay != 16'h0000) begin
                  nxt_st.seq     = DWS_DELAY; // RQ2
                  nxt_st.dly_cnt = st_ff.trig_delay;
               end else begin
                  nxt_st.seq = DWS_RUN; // RQ1
               end
            end
         end
         DWS_DELAY: begin
            if (stop_cmd) begin
               nxt_st.seq = DWS_IDLE; // RQ13
            end else if (dly_tick) begin
               nxt_st.dly_cnt = st_ff.dly_cnt - 16'h0001; // RQ2
               if (st_ff.dly_cnt == 16'h0001) begin
                  nxt_st.seq    = DWS_RUN; // RQ2
                  nxt_st.ui_cnt = 24'h000000;
               end
            end
         end
         DWS_RUN: begin
            if (rd_take) begin
               nxt_st.strobe  = 1'b1; // RQ19
               nxt_st.ch0     = mem[st_ff.rd_ptr];
               nxt_st.ch1     = dual ? mem[ptr_add(st_ff.rd_ptr, 2'h1)] : st_ff.ch1;
               nxt_st.rd_ptr  = ptr_add(st_ff.rd_ptr, wpu);
               nxt_st.smp_cnt = st_ff.smp_cnt + 24'h000001;
               if (!replay) begin
                  fill_tmp = fill_tmp - {{(AW-1){1'b0}}, wpu}; // RQ9
               end
            end else if (upd_tick) begin
               nxt_st.underrun = 1'b1;
            end
            if (stop_cmd && stop_mode == `DWS_STOP_NOW) begin
               nxt_st.seq    = DWS_IDLE; // RQ14
               nxt_st.strobe = 1'b0;
               // no output change without its strobe
               nxt_st.ch0    = st_ff.ch0;
               nxt_st.ch1    = st_ff.ch1;
            end else begin
               if (stop_cmd) begin
                  nxt_st.stop_pend = 1'b1; // RQ13
               end
               if (wave_end) begin
                  nxt_st.smp_cnt  = 24'h000000;
                  nxt_st.iter_cnt = group_end ? 24'h000000 : iter_next; // RQ5
                  if (replay) begin
                     nxt_st.rd_ptr = '0; // RQ8
                  end
                  if (stop_here) begin
                     nxt_st.seq = DWS_IDLE; // RQ15 RQ16 RQ22
                  end else if (group_end && !st_ff.cfg[`DWS_CFG_INFINITE]) begin
                     if (st_ff.cfg[`DWS_CFG_RETRIG_EN] && st_ff.retrig_left != 16'h0000) begin
                        nxt_st.seq         = DWS_ARMED; // RQ4
                        nxt_st.retrig_left = st_ff.retrig_left - 16'h0001;
                     end else begin
                        nxt_st.seq = DWS_IDLE; // RQ7 RQ22
                     end
                  end else if (st_ff.gap != 16'h0000) begin
                     nxt_st.seq     = DWS_GAP; // RQ11
                     nxt_st.dly_cnt = st_ff.gap;
                  end
               end
            end
         end
         DWS_GAP: begin
            if (stop_cmd && (stop_mode != `DWS_STOP_GROUP || st_ff.iter_cnt == 24'h000000)) begin
               nxt_st.seq = DWS_IDLE; // RQ13 RQ16
            end else begin
               if (stop_cmd) begin
                  nxt_st.stop_pend = 1'b1;
               end
               if (gap_tick) begin
                  nxt_st.dly_cnt = st_ff.dly_cnt - 16'h0001; // RQ11
                  if (st_ff.dly_cnt == 16'h0001) begin
                     nxt_st.seq    = DWS_RUN;
                     nxt_st.ui_cnt = 24'h000000;
                  end
               end
            end
         end
      endcase

      nxt_st.fill = fill_tmp;
      if (WR && ADDR == `DWS_OFS_CTRL && WDATA[`DWS_CTRL_FLUSH] && st_ff.seq == DWS_IDLE) begin
         nxt_st.fill   = '0;
         nxt_st.rd_ptr = '0;
         nxt_st.wr_ptr = '0;
      end
      // a fresh underrun wins over a clear in the same cycle
      if (st_ff.seq == DWS_RUN && upd_tick && !rd_take) begin
         nxt_st.underrun = 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_ff <= '{seq: DWS_IDLE, cfg: `DWS_CFG_RESET, interval: `DWS_INTERVAL_RESET,
                    samples: `DWS_SAMPLES_RESET, iter: `DWS_ITER_RESET, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign RDATA                   = st_ff.rdata;
   assign CH0_DATA                = st_ff.ch0;
   assign CH1_DATA                = st_ff.ch1;
   assign CONVERTER_UPDATE_STROBE = st_ff.strobe;
   assign BUSY                    = st_ff.seq != DWS_IDLE;

endmodule

// [bench/dws_checker_properties.sv]
// port assertions for the waveform sequencer
`timescale 1ns/100ps
`include "dws_consts.svh"
module dws_checker #(
   parameter int DEPTH = 1024,
   parameter int DW    = 12
) (
   // clock and reset
   input wire logic                   CLOCK,
   input wire logic                   RST,
   // register port
   input wire logic [`DWS_ADDR_W-1:0] ADDR,
   input wire logic [31:0]            WDATA,
   input wire logic                   WR,
   // converter side
   input wire logic [DW-1:0]          CH0_DATA,
   input wire logic [DW-1:0]          CH1_DATA,
   input wire logic                   CONVERTER_UPDATE_STROBE,
   input wire logic                   BUSY
);
   logic        ctl_wr;
   logic        go;
   logic [1:0]  stop_md_ff;
   logic [23:0] ivl_ff;
   logic [23:0] smp_ff;
   logic [23:0] iter_ff;
   logic [23:0] since_ff;
   logic [23:0] ups_ff;
   logic        seen_ff;
   assign ctl_wr = WR && ADDR == `DWS_OFS_CTRL;
   assign go = ctl_wr && WDATA[`DWS_CTRL_START];
   // shadow of the settings and strobe history
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         stop_md_ff <= 2'h0;
         ivl_ff <= `DWS_INTERVAL_RESET;
         smp_ff <= `DWS_SAMPLES_RESET;
         iter_ff <= `DWS_ITER_RESET;
         since_ff <= 24'h0;
         ups_ff <= 24'h0;
         seen_ff <= 1'b0;
      end else begin
         if (WR && ADDR == `DWS_OFS_CONFIG) stop_md_ff <= WDATA[6:5];
         if (WR && ADDR == `DWS_OFS_INTERVAL) ivl_ff <= WDATA[23:0];
         if (WR && ADDR == `DWS_OFS_SAMPLES) smp_ff <= WDATA[23:0];
         if (WR && ADDR == `DWS_OFS_ITER) iter_ff <= WDATA[23:0];
         since_ff <= CONVERTER_UPDATE_STROBE ? 24'h1 : since_ff + {23'h0, since_ff != 24'hffffff};
         ups_ff <= go ? 24'h0 : ups_ff + {23'h0, CONVERTER_UPDATE_STROBE};
         seen_ff <= seen_ff | CONVERTER_UPDATE_STROBE;
      end
   end
   idle_quiet_a: assert property (@(posedge CLOCK) disable iff (RST)
      !BUSY && !$past(BUSY) |-> !CONVERTER_UPDATE_STROBE) else $error("strobe while idle");
   stay_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
      !BUSY && !go && !$past(go) |=> !BUSY) else $error("left idle without start");
   start_arm_a: assert property (@(posedge CLOCK) disable iff (RST)
      !BUSY && go && !WDATA[`DWS_CTRL_STOP] |-> ##[1:2] BUSY) else $error("start not taken");
   stop_now_a: assert property (@(posedge CLOCK) disable iff (RST)
      BUSY && ctl_wr && WDATA[`DWS_CTRL_STOP] && stop_md_ff == `DWS_STOP_NOW |-> ##[1:2] !BUSY)
      else $error("immediate stop late");
   hold_out_a: assert property (@(posedge CLOCK) disable iff (RST)
      !CONVERTER_UPDATE_STROBE |-> $stable(CH0_DATA) && $stable(CH1_DATA))
      else $error("output changed without strobe");
   strobe_space_a: assert property (@(posedge CLOCK) disable iff (RST)
      CONVERTER_UPDATE_STROBE && seen_ff |-> since_ff >= ((ivl_ff == 24'h0) ? 24'h1 : ivl_ff))
      else $error("updates too close");
   wave_end_a: assert property (@(posedge CLOCK) disable iff (RST)
      $fell(BUSY) && stop_md_ff == `DWS_STOP_WAVE |-> ##2 ups_ff % smp_ff == 24'h0)
      else $error("stop cut a waveform");
   group_end_a: assert property (@(posedge CLOCK) disable iff (RST)
      $fell(BUSY) && stop_md_ff == `DWS_STOP_GROUP |-> ##2 ups_ff % (smp_ff * iter_ff) == 24'h0)
      else $error("stop cut a group");
endmodule
bind dws_sequencer dws_checker #(.DEPTH(DEPTH), .DW(DW)) CHK (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .CH0_DATA(CH0_DATA), .CH1_DATA(CH1_DATA),
   .CONVERTER_UPDATE_STROBE(CONVERTER_UPDATE_STROBE), .BUSY(BUSY));

// [bench/dws_host_dma.sv]
// host dma model feeding numbered sample words
`timescale 1ns/100ps
module dws_host_dma (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  rst,
   // enable, low restarts numbering
   input  wire logic  en,
   // sample stream
   input  wire logic  ready,
   output logic [11:0] data,
   output logic       valid
);
   logic [11:0] count_ff;
   logic [11:0] nxt;
   logic        go;
   // word held until taken; idle data toggles
   always @(posedge clock) begin
      if (rst) begin
         valid <= 1'b0;
         count_ff <= 12'h0;
         data <= 12'h0;
      end else if (!valid || ready) begin
         go = en && ($urandom % 8 != 0);
         nxt = count_ff + {11'h0, valid};
         count_ff <= en ? nxt : 12'h0;
         valid <= go;
         data <= go ? nxt + 12'h1 : ~data;
      end
   end
endmodule

// [bench/dac_waveform_sequencer_tb_top.sv]
// self-checking bench for the waveform sequencer
`timescale 1ns/100ps
`include "dws_consts.svh"
module dac_waveform_sequencer_tb_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wr_s = 1'b0;
   logic        rd_s = 1'b0;
   logic        atrig = 1'b0;
   logic        dtrig = 1'b0;
   logic        en = 1'b0;
   logic        strobe, busy, s_ready, s_valid;
   logic [11:0] s_data, ch0, ch1;
   int          num_errors = 0;
   int          num_checks = 0;
   int          k, s_len, stream, dual, t0, i, mi, d, lo, m;
   int          cyc = 0;
   int          ts[$];
   always #20 clock = ~clock;
   always @(posedge clock) cyc++;
   dws_sequencer DUT (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .SAMPLE_DATA(s_data), .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready),
      .ANALOG_TRIG(atrig), .DIGITAL_TRIG(dtrig), .CH0_DATA(ch0), .CH1_DATA(ch1),
      .CONVERTER_UPDATE_STROBE(strobe), .BUSY(busy));
   dws_host_dma HOST (.clock(clock), .rst(rst), .en(en), .ready(s_ready), .data(s_data), .valid(s_valid));
   task automatic give_verdict();
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_smp(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clock);
      wr_s <= 1'b0;
   endtask
   task automatic rdw(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clock);
      rd_s <= 1'b0;
      #1 chk_word(rdata, exp);
   endtask
   // n below zero waits for idle
   task automatic wait_for(input int n);
      int c;
      c = 0;
      while ((n < 0) ? (busy !== 1'b0) : (k < n)) begin
         @(posedge clock);
         c++;
         if (c > 6000) begin
            num_errors++;
            give_verdict();
         end
      end
   endtask
   task automatic trig(input int src);
      if (src == 0) wr(`DWS_OFS_CTRL, 32'h4);
      else begin
         if (src == 1) atrig <= 1'b1;
         else dtrig <= 1'b1;
         repeat (3) @(posedge clock);
         atrig <= 1'b0;
         dtrig <= 1'b0;
      end
      t0 = cyc;
   endtask
   task automatic setup(input logic [31:0] cfg, ivl, sl, it, gp, dl, rt);
      en <= 1'b0;
      wr(`DWS_OFS_CTRL, 32'h10);
      repeat (4) @(posedge clock);
      wr(`DWS_OFS_CTRL, 32'h10);
      wr(`DWS_OFS_CONFIG, cfg);
      wr(`DWS_OFS_INTERVAL, ivl);
      wr(`DWS_OFS_SAMPLES, sl);
      wr(`DWS_OFS_ITER, it);
      wr(`DWS_OFS_GAP, gp);
      wr(`DWS_OFS_TRIG_DELAY, dl);
      wr(`DWS_OFS_RETRIG, rt);
      s_len = sl;
      dual = cfg[9];
      stream = sl * (dual + 1) > 1024;
      k = 0;
      ts = {};
      en <= 1'b1;
      repeat (40) @(posedge clock);
      wr(`DWS_OFS_CTRL, 32'h1);
   endtask
   // reference of the expected sample at each update
   always @(negedge clock) begin
      if (!rst && strobe === 1'b1) begin
         mi = stream ? k : k % s_len;
         mi = dual ? 2 * mi : mi;
         chk_smp(ch0, 12'(mi + 1));
         if (dual) chk_smp(ch1, 12'(mi + 2));
         ts.push_back(cyc);
         k++;
      end
   end
   initial begin
      void'($urandom(32'ha82e));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rdw(`DWS_OFS_CONFIG, 32'h0);
      rdw(`DWS_OFS_INTERVAL, 32'h28);
      rdw(`DWS_OFS_SAMPLES, 32'h1);
      rdw(8'h24, 32'h0);
      wr(`DWS_OFS_TRIG_DELAY, 32'hffffffff);
      rdw(`DWS_OFS_TRIG_DELAY, 32'hffff);
      for (i = 0; i < 3; i++) begin
         d = 10 + $urandom % 20;
         setup(i | (i > 0 ? 4 : 0) | (i == 2 ? 32'h80 : 0), 3, 2, 1, 0, d, 0);
         trig(i == 1 ? 2 : 1);
         repeat (30) @(posedge clock);
         chk_word(32'(k), 32'h0);
         trig(i);
         wait_for(-1);
         lo = (i == 0) ? 3 : (i == 1) ? d + 3 : d * 3 + 3;
         chk_word(32'(ts[0] - t0 >= lo - 2 && ts[0] - t0 <= lo + 8), 32'h1);
         chk_word(32'(k), 32'h2);
      end
      for (i = 0; i < 2; i++) begin
         setup(i ? 32'h100 : 32'h0, 3, 4, 2, 7, 0, 0);
         chk_word({31'h0, s_ready}, 32'h0);
         trig(0);
         wait_for(-1);
         chk_word(32'(k), 32'h8);
         lo = i ? 24 : 10;
         chk_word(32'(ts[4] - ts[3] >= lo - 1 && ts[4] - ts[3] <= lo + 4), 32'h1);
      end
      setup(32'h8, 3, 2, 2, 0, 0, 1);
      trig(0);
      repeat (6) @(posedge clock);
      trig(0);
      wait_for(4);
      repeat (20) @(posedge clock);
      chk_word(32'(k), 32'h4);
      trig(0);
      wait_for(-1);
      trig(0);
      repeat (30) @(posedge clock);
      chk_word(32'(k), 32'h8);
      chk_word({31'h0, busy}, 32'h0);
      for (i = 0; i < 3; i++) begin
         setup(32'h10 | (i << 5), 2, 4, 3, 0, 0, 0);
         trig(0);
         repeat (60 + $urandom % 60) @(posedge clock);
         wr(`DWS_OFS_CTRL, 32'h2);
         wait_for(-1);
         m = (i == 2) ? 12 : (i == 1) ? 4 : 1;
         chk_word(32'(k % m == 0 && k > 12), 32'h1);
      end
      setup(32'h0, 2, 1030, 1, 0, 0, 0);
      trig(0);
      wait_for(-1);
      chk_word(32'(k), 32'd1030);
      setup(32'h200, 3, 3, 2, 0, 0, 0);
      trig(0);
      wait_for(-1);
      chk_word(32'(k), 32'h6);
      give_verdict();
   end
endmodule
